// [rtl/fcp_pkg.sv]
package fcp_pkg;
    // ==========================================================
    // Command byte decoding
    // ==========================================================
    localparam logic [2:0] OPSEL_FIXED = 3'h1;
    localparam int OPSEL_FIXED_LSB = 5;
    localparam int OPSEL_KIND_LSB = 3;
    localparam int OPSEL_ZERO_BIT = 2;
    localparam int OPSEL_LOP_LSB = 0;
    localparam logic [1:0] TRANSFER_WORD = 2'h0;
    localparam logic [1:0] LOP_REPLACE = 2'h0;
    localparam logic [1:0] LOP_COMPLEMENT = 2'h1;
    localparam logic [1:0] LOP_CLEAR = 2'h2;
    localparam logic [1:0] LOP_SET = 2'h3;
    localparam logic [7:0] CMD_CURSOR_SET = 8'h10;
    localparam logic [7:0] CMD_FIGURE_SPEC = 8'h11;
    localparam logic [7:0] CMD_FIGURE_DRAW = 8'h12;
    localparam logic [7:0] CMD_GLYPH_FILL = 8'h13;
    localparam logic [3:0] CMD_PARAM_RAM_LOAD_COMMAND_LOAD_HI = 4'h7;

    // ==========================================================
    // Parameter RAM and pattern
    // ==========================================================
    localparam int PARAM_RAM_LOAD_COMMAND_DEPTH = 16;
    localparam int PARAM_RAM_LOAD_COMMAND_PATTERN_LO = 8;
    localparam int PARAM_RAM_LOAD_COMMAND_PATTERN_HI = 9;
    localparam int PARAM_RAM_LOAD_COMMAND_GLYPH_FIRST = 8;
    localparam int PARAM_RAM_LOAD_COMMAND_GLYPH_LAST = 15;
    localparam int PATTERN_PERIOD = 16;

    // ==========================================================
    // Figure specification
    // ==========================================================
    localparam int VAR_W = 14;
    localparam int VAR_HI_BITS = 6;
    localparam logic [13:0] STEP_INIT = 14'h0000;
    localparam logic [13:0] ERROR_INIT = 14'h0008;
    localparam logic [13:0] D2_INIT = 14'h3fff;
    localparam logic [13:0] MASK_INIT = 14'h3fff;
    localparam int FTYPE_LSB = 3;
    localparam int OCTANT_LSB = 0;
    localparam logic [4:0] FT_DOT = 5'h00;
    localparam logic [4:0] FT_LINE = 5'h01;
    localparam logic [4:0] FT_GLYPH = 5'h02;
    localparam logic [4:0] FT_ARC = 5'h04;
    localparam logic [4:0] FT_RECT = 5'h08;
    localparam logic [4:0] FT_SLANT_GLYPH = 5'h12;

    typedef enum logic [2:0] {
        VAR_TYPE, VAR_STEP, VAR_ERROR, VAR_D2, VAR_D1, VAR_MASK, VAR_DONE
    } fcp_var_t;

    typedef enum logic [2:0] {
        MODE_IDLE, MODE_MEMWRITE, MODE_CURSOR, MODE_FIGSPEC, MODE_PARAM_RAM_LOAD_COMMAND
    } fcp_mode_t;

    // ==========================================================
    // Host register map
    // ==========================================================
    localparam logic [31:0] REG_SEND = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam int SEND_CMD_BIT = 8;
    localparam int STAT_PENDING_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;

    // ==========================================================
    // Shared functions
    // ==========================================================
    function automatic logic is_opsel(input logic [7:0] b);
        return b[7:OPSEL_FIXED_LSB] == OPSEL_FIXED && !b[OPSEL_ZERO_BIT];
    endfunction

    function automatic logic fig_type_valid(input logic [4:0] t);
        return t == FT_DOT || t == FT_LINE || t == FT_GLYPH ||
            t == FT_ARC || t == FT_RECT || t == FT_SLANT_GLYPH;
    endfunction

    function automatic logic apply_lop(input logic [1:0] op,
        input logic pat, input logic pix);
        logic r;
        r = pix;
        unique case (op)
            LOP_REPLACE: r = pat;
            LOP_COMPLEMENT: r = pix ^ pat;
            LOP_CLEAR: r = pix & ~pat;
            LOP_SET: r = pix | pat;
        endcase
        return r;
    endfunction
endpackage

// [rtl/fcp_link_if.sv]
`timescale 1ns/100ps
interface fcp_link_if (
    input wire logic hclk,
    input wire logic hresetn
);
    logic entry_valid;
    logic entry_ready;
    logic entry_is_cmd;
    logic [7:0] entry_byte;
    logic drawing_busy;

    modport host (
        output entry_valid,
        output entry_is_cmd,
        output entry_byte,
        input entry_ready,
        input drawing_busy
    );

    modport device (
        input entry_valid,
        input entry_is_cmd,
        input entry_byte,
        output entry_ready,
        output drawing_busy
    );
endinterface

// [rtl/fcp_pattern_unit.sv]
`timescale 1ns/100ps
module fcp_pattern_unit (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic load,
    input wire logic [15:0] pattern_word,
    input wire logic [1:0] logic_op,
    // Drawing engine
    input wire logic rmw_cycle,
    input wire logic pixel_in,
    output logic pattern_bit,
    output logic modified_pixel,
    output logic modified_valid
);
    logic [15:0] pattern;
    logic [3:0] bit_sel;
    logic [15:0] next_pattern;
    logic [3:0] next_bit_sel;
    logic next_modified_pixel;
    logic next_modified_valid;

    assign pattern_bit = pattern[bit_sel];

    // ==========================================================
    // Pattern scan
    // ==========================================================
    // Scan order ignores figure type and octant on purpose
    always_comb
    begin
        next_pattern = pattern;
        next_bit_sel = bit_sel;
        next_modified_pixel = modified_pixel;
        next_modified_valid = 1'b0;
        if (load)
        begin
            next_pattern = pattern_word;
            next_bit_sel = 4'h0;
        end
        else if (rmw_cycle)
        begin
            next_modified_pixel = fcp_pkg::apply_lop(logic_op,
                pattern[bit_sel], pixel_in);
            next_modified_valid = 1'b1;
            // Four bits wrap at the period of sixteen
            next_bit_sel = bit_sel + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pattern <= 16'h0000;
            bit_sel <= 4'h0;
            modified_pixel <= 1'b0;
            modified_valid <= 1'b0;
        end
        else
        begin
            pattern <= next_pattern;
            bit_sel <= next_bit_sel;
            modified_pixel <= next_modified_pixel;
            modified_valid <= next_modified_valid;
        end
    end
endmodule

// [rtl/fcp_device.sv]
`timescale 1ns/100ps
module fcp_device (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Command and parameter entries
    fcp_link_if.device link,
    // Drawing engine
    input wire logic rmw_cycle,
    input wire logic pixel_in,
    output logic pattern_bit,
    output logic modified_pixel,
    output logic modified_valid,
    output logic draw_start,
    output logic glyph_start,
    output logic [63:0] glyph_pattern,
    // Operation setup
    output logic [1:0] logic_op_select,
    output logic [1:0] transfer_kind,
    output logic mem_word_valid,
    output logic [15:0] mem_word,
    // Cursor
    output logic [15:0] word_pointer,
    output logic [15:0] bit_position_mask,
    // Figure variables
    output logic [4:0] figure_type,
    output logic figure_type_valid,
    output logic [2:0] octant,
    output logic [13:0] step_count,
    output logic [13:0] error_term,
    output logic [13:0] second_difference,
    output logic [13:0] first_difference,
    output logic [13:0] mask_length
);
    fcp_pkg::fcp_mode_t mode, next_mode;
    fcp_pkg::fcp_var_t var_idx, next_var_idx;
    logic phase, next_phase;
    logic [7:0] low_byte, next_low_byte;
    logic [1:0] cur_idx, next_cur_idx;
    logic [3:0] param_ram_load_command_addr, next_param_ram_load_command_addr;
    logic [7:0] param_ram_load_command [fcp_pkg::PARAM_RAM_LOAD_COMMAND_DEPTH];
    logic [7:0] next_param_ram_load_command [fcp_pkg::PARAM_RAM_LOAD_COMMAND_DEPTH];
    logic [1:0] next_logic_op_select, next_transfer_kind;
    logic next_mem_word_valid;
    logic [15:0] next_mem_word;
    logic [15:0] next_word_pointer, next_bit_position_mask;
    logic [4:0] next_figure_type;
    logic [2:0] next_octant;
    logic [13:0] next_step_count, next_error_term;
    logic [13:0] next_second_difference, next_first_difference;
    logic [13:0] next_mask_length;
    logic next_draw_start, next_glyph_start;
    logic busy, next_busy;
    logic [14:0] remain, next_remain;
    logic take;
    logic [7:0] b;
    logic [13:0] word14;

    // Entries are refused while a figure is being drawn
    assign link.entry_ready = !busy;
    assign link.drawing_busy = busy;
    assign take = link.entry_valid && link.entry_ready;
    assign b = link.entry_byte;
    assign word14 = {b[fcp_pkg::VAR_HI_BITS-1:0], low_byte};
    assign figure_type_valid = fcp_pkg::fig_type_valid(figure_type);

    // ==========================================================
    // Glyph pattern view
    // ==========================================================
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            glyph_pattern[i*8 +: 8] = param_ram_load_command[fcp_pkg::PARAM_RAM_LOAD_COMMAND_GLYPH_FIRST + i];
        end
    end

    // ==========================================================
    // Command interpreter
    // ==========================================================
    always_comb
    begin
        next_mode = mode;
        next_var_idx = var_idx;
        next_phase = phase;
        next_low_byte = low_byte;
        next_cur_idx = cur_idx;
        next_param_ram_load_command_addr = param_ram_load_command_addr;
        next_param_ram_load_command = param_ram_load_command;
        next_logic_op_select = logic_op_select;
        next_transfer_kind = transfer_kind;
        next_mem_word_valid = 1'b0;
        next_mem_word = mem_word;
        next_word_pointer = word_pointer;
        next_bit_position_mask = bit_position_mask;
        next_figure_type = figure_type;
        next_octant = octant;
        next_step_count = step_count;
        next_error_term = error_term;
        next_second_difference = second_difference;
        next_first_difference = first_difference;
        next_mask_length = mask_length;
        next_draw_start = 1'b0;
        next_glyph_start = 1'b0;
        next_busy = busy;
        next_remain = remain;
        if (busy && rmw_cycle)
        begin
            // First pixel is the extra cycle beyond the step count
            next_remain = remain - 15'h0001;
            next_busy = remain != 15'h0001;
        end
        if (take && link.entry_is_cmd)
        begin
            // Any command ends the previous parameter sequence
            next_mode = fcp_pkg::MODE_IDLE;
            next_phase = 1'b0;
            if (fcp_pkg::is_opsel(b))
            begin
                next_transfer_kind = b[fcp_pkg::OPSEL_KIND_LSB +: 2];
                next_logic_op_select = b[fcp_pkg::OPSEL_LOP_LSB +: 2];
                next_mode = fcp_pkg::MODE_MEMWRITE;
            end
            else if (b[7:4] == fcp_pkg::CMD_PARAM_RAM_LOAD_COMMAND_LOAD_HI)
            begin
                next_mode = fcp_pkg::MODE_PARAM_RAM_LOAD_COMMAND;
                next_param_ram_load_command_addr = b[3:0];
            end
            else if (b == fcp_pkg::CMD_CURSOR_SET)
            begin
                next_mode = fcp_pkg::MODE_CURSOR;
                next_cur_idx = 2'h0;
            end
            else if (b == fcp_pkg::CMD_FIGURE_SPEC)
            begin
                next_mode = fcp_pkg::MODE_FIGSPEC;
                next_var_idx = fcp_pkg::VAR_TYPE;
                next_step_count = fcp_pkg::STEP_INIT;
                next_error_term = fcp_pkg::ERROR_INIT;
                next_second_difference = fcp_pkg::D2_INIT;
                next_mask_length = fcp_pkg::MASK_INIT;
            end
            else if (b == fcp_pkg::CMD_FIGURE_DRAW ||
                b == fcp_pkg::CMD_GLYPH_FILL)
            begin
                next_draw_start = b == fcp_pkg::CMD_FIGURE_DRAW;
                next_glyph_start = b == fcp_pkg::CMD_GLYPH_FILL;
                next_busy = 1'b1;
                next_remain = {1'b0, step_count} + 15'h0001;
            end
        end
        else if (take)
        begin
            unique case (mode)
                fcp_pkg::MODE_IDLE:
                begin
                end
                fcp_pkg::MODE_MEMWRITE:
                begin
                    // Low byte first; a lone odd byte is dropped
                    next_phase = !phase;
                    next_low_byte = b;
                    if (phase)
                    begin
                        next_mem_word = {b, low_byte};
                        next_mem_word_valid = 1'b1;
                    end
                end
                fcp_pkg::MODE_CURSOR:
                begin
                    unique case (cur_idx)
                        2'h0: next_word_pointer[7:0] = b;
                        2'h1: next_word_pointer[15:8] = b;
                        2'h2: next_bit_position_mask =
                            16'h0001 << b[3:0];
                        2'h3:
                        begin
                        end
                    endcase
                    if (cur_idx != 2'h3)
                    begin
                        next_cur_idx = cur_idx + 2'h1;
                    end
                end
                fcp_pkg::MODE_PARAM_RAM_LOAD_COMMAND:
                begin
                    next_param_ram_load_command[param_ram_load_command_addr] = b;
                    next_param_ram_load_command_addr = param_ram_load_command_addr + 4'h1;
                end
                fcp_pkg::MODE_FIGSPEC:
                begin
                    if (var_idx == fcp_pkg::VAR_TYPE)
                    begin
                        next_figure_type = b[fcp_pkg::FTYPE_LSB +: 5];
                        next_octant = b[fcp_pkg::OCTANT_LSB +: 3];
                        next_var_idx = fcp_pkg::VAR_STEP;
                    end
                    else if (var_idx != fcp_pkg::VAR_DONE)
                    begin
                        next_phase = !phase;
                        next_low_byte = b;
                        if (phase)
                        begin
                            unique case (var_idx)
                                fcp_pkg::VAR_STEP: next_step_count = word14;
                                fcp_pkg::VAR_ERROR: next_error_term = word14;
                                fcp_pkg::VAR_D2:
                                    next_second_difference = word14;
                                fcp_pkg::VAR_D1:
                                    next_first_difference = word14;
                                fcp_pkg::VAR_MASK: next_mask_length = word14;
                                default:
                                begin
                                end
                            endcase
                            // Strictly sequential, so no variable is skipped
                            next_var_idx = fcp_pkg::fcp_var_t'(
                                var_idx + 3'h1);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode <= fcp_pkg::MODE_IDLE;
            var_idx <= fcp_pkg::VAR_TYPE;
            phase <= 1'b0;
            low_byte <= 8'h00;
            cur_idx <= 2'h0;
            param_ram_load_command_addr <= 4'h0;
            for (int i = 0; i < fcp_pkg::PARAM_RAM_LOAD_COMMAND_DEPTH; i++)
            begin
                param_ram_load_command[i] <= 8'h00;
            end
            logic_op_select <= fcp_pkg::LOP_REPLACE;
            transfer_kind <= fcp_pkg::TRANSFER_WORD;
            mem_word_valid <= 1'b0;
            mem_word <= 16'h0000;
            word_pointer <= 16'h0000;
            bit_position_mask <= 16'h0001;
            figure_type <= fcp_pkg::FT_DOT;
            octant <= 3'h0;
            step_count <= fcp_pkg::STEP_INIT;
            error_term <= fcp_pkg::ERROR_INIT;
            second_difference <= fcp_pkg::D2_INIT;
            first_difference <= 14'h0000;
            mask_length <= fcp_pkg::MASK_INIT;
            draw_start <= 1'b0;
            glyph_start <= 1'b0;
            busy <= 1'b0;
            remain <= 15'h0000;
        end
        else
        begin
            mode <= next_mode;
            var_idx <= next_var_idx;
            phase <= next_phase;
            low_byte <= next_low_byte;
            cur_idx <= next_cur_idx;
            param_ram_load_command_addr <= next_param_ram_load_command_addr;
            param_ram_load_command <= next_param_ram_load_command;
            logic_op_select <= next_logic_op_select;
            transfer_kind <= next_transfer_kind;
            mem_word_valid <= next_mem_word_valid;
            mem_word <= next_mem_word;
            word_pointer <= next_word_pointer;
            bit_position_mask <= next_bit_position_mask;
            figure_type <= next_figure_type;
            octant <= next_octant;
            step_count <= next_step_count;
            error_term <= next_error_term;
            second_difference <= next_second_difference;
            first_difference <= next_first_difference;
            mask_length <= next_mask_length;
            draw_start <= next_draw_start;
            glyph_start <= next_glyph_start;
            busy <= next_busy;
            remain <= next_remain;
        end
    end

    // ==========================================================
    // Pattern register and pixel modify
    // ==========================================================
    fcp_pattern_unit u_pattern (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(next_draw_start || next_glyph_start),
        .pattern_word({param_ram_load_command[fcp_pkg::PARAM_RAM_LOAD_COMMAND_PATTERN_HI],
            param_ram_load_command[fcp_pkg::PARAM_RAM_LOAD_COMMAND_PATTERN_LO]}),
        .logic_op(logic_op_select),
        .rmw_cycle(rmw_cycle && busy),
        .pixel_in(pixel_in),
        .pattern_bit(pattern_bit),
        .modified_pixel(modified_pixel),
        .modified_valid(modified_valid)
    );
endmodule

// [rtl/fcp_host.sv]
`timescale 1ns/100ps
module fcp_host (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Link to the device
    fcp_link_if.host link
);
    logic dp_send, next_dp_send;
    logic pending, next_pending;
    logic is_cmd, next_is_cmd;
    logic [7:0] send_byte, next_send_byte;
    logic [31:0] next_hrdata;
    logic addr_ok;

    assign addr_ok = hsel && htrans[1] && hready;
    // Stall a second write until the device took the first
    assign hreadyout = !(dp_send && pending);
    assign hresp = 1'b0;
    assign link.entry_valid = pending;
    assign link.entry_is_cmd = is_cmd;
    assign link.entry_byte = send_byte;

    // ==========================================================
    // Bus slave and entry holding
    // ==========================================================
    always_comb
    begin
        next_dp_send = dp_send;
        next_pending = pending;
        next_is_cmd = is_cmd;
        next_send_byte = send_byte;
        next_hrdata = hrdata;
        if (pending && link.entry_ready)
        begin
            next_pending = 1'b0;
        end
        if (dp_send && !pending)
        begin
            // Software orders the bytes; this end forwards them as is
            next_send_byte = hwdata[7:0];
            next_is_cmd = hwdata[fcp_pkg::SEND_CMD_BIT];
            next_pending = 1'b1;
            next_dp_send = 1'b0;
        end
        if (addr_ok)
        begin
            next_dp_send = hwrite && haddr == fcp_pkg::REG_SEND;
            next_hrdata = 32'h0000_0000;
            if (!hwrite && haddr == fcp_pkg::REG_SEND)
            begin
                next_hrdata[7:0] = send_byte;
                next_hrdata[fcp_pkg::SEND_CMD_BIT] = is_cmd;
            end
            else if (!hwrite && haddr == fcp_pkg::REG_STATUS)
            begin
                next_hrdata[fcp_pkg::STAT_PENDING_BIT] = next_pending;
                next_hrdata[fcp_pkg::STAT_BUSY_BIT] = link.drawing_busy;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_send <= 1'b0;
            pending <= 1'b0;
            is_cmd <= 1'b0;
            send_byte <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            dp_send <= next_dp_send;
            pending <= next_pending;
            is_cmd <= next_is_cmd;
            send_byte <= next_send_byte;
            hrdata <= next_hrdata;
        end
    end
endmodule

// [verif/fcp_link_monitor.sv]
`timescale 1ns/100ps
module fcp_link_monitor (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link
    input wire logic entry_valid,
    input wire logic entry_ready,
    input wire logic entry_is_cmd,
    input wire logic [7:0] entry_byte,
    input wire logic drawing_busy
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = entry_valid && entry_ready;
    wire go = take && entry_is_cmd && entry_byte[7:1] == 7'h09;
    sequence s_wait;
        entry_valid && !entry_ready;
    endsequence
    sequence s_go;
        go ##1 drawing_busy;
    endsequence
    // ====
    // Link checks
    chk_ready_busy: assert property (entry_ready == !drawing_busy)
        else $error("ready not inverse of busy");
    chk_valid_held: assert property (s_wait |=> entry_valid)
        else $error("entry dropped before taken");
    chk_byte_held: assert property (s_wait |=> $stable(entry_byte))
        else $error("entry byte changed while waiting");
    chk_flag_held: assert property (s_wait |=> $stable(entry_is_cmd))
        else $error("entry flag changed while waiting");
    chk_start_busy: assert property (go |-> s_go)
        else $error("start command did not raise busy");
    chk_busy_cause: assert property ($rose(drawing_busy) |-> $past(go))
        else $error("busy without start command");
    chk_fell_taken: assert property ($fell(entry_valid) |-> $past(take))
        else $error("entry withdrawn untaken");
    chk_take_drop: assert property (take |=> !entry_valid)
        else $error("entry still valid after take");
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, read_modify_write_cycle = 0, pix = 0;
    logic hreadyout, mp, mwv, ftv, pb, mv, ds, gs;
    logic [1:0] htrans = 0, lop, tk, op;
    logic [2:0] oc;
    logic [4:0] ft;
    logic [15:0] mw, pat, wp, bm;
    logic [63:0] gp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r, rn;
    logic [13:0] v [5];
    logic [13:0] e [5];
    logic [4:0] ty [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h12};
    int err_total = 0, samples_checked = 0, words = 0, nd = 0, ng = 0;
    always #2 hclk = ~hclk;
    always @(posedge hclk)
    begin
        if (mwv === 1'b1) words <= words + 1;
        if (ds === 1'b1) nd <= nd + 1;
        if (gs === 1'b1) ng <= ng + 1;
    end
    fcp_link_if fcp_link_if_i (.hclk, .hresetn);
    fcp_host fcp_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp(),
        .hrdata, .link(fcp_link_if_i));
    fcp_device fcp_device_i (.hclk, .hresetn, .link(fcp_link_if_i),
        .rmw_cycle(read_modify_write_cycle), .pixel_in(pix), .pattern_bit(pb),
        .modified_pixel(mp), .modified_valid(mv), .draw_start(ds),
        .glyph_start(gs), .glyph_pattern(gp),
        .logic_op_select(lop), .transfer_kind(tk), .mem_word_valid(mwv),
        .mem_word(mw), .word_pointer(wp), .bit_position_mask(bm),
        .figure_type(ft), .figure_type_valid(ftv), .octant(oc),
        .step_count(v[0]), .error_term(v[1]), .second_difference(v[2]),
        .first_difference(v[3]), .mask_length(v[4]));
    fcp_link_monitor fcp_link_monitor_i (.hclk, .hresetn,
        .entry_valid(fcp_link_if_i.entry_valid),
        .entry_ready(fcp_link_if_i.entry_ready),
        .entry_is_cmd(fcp_link_if_i.entry_is_cmd),
        .entry_byte(fcp_link_if_i.entry_byte),
        .drawing_busy(fcp_link_if_i.drawing_busy));
    // ====
    // Tasks
    task end_sim;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] x, y);
        samples_checked++;
        if (y !== x)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", n, x, y);
        end
    endtask
    function logic lf(input logic [1:0] o, input logic p, x);
        case (o)
            2'h0: return p;
            2'h1: return x ^ p;
            2'h2: return x & ~p;
            default: return x | p;
        endcase
    endfunction
    // Sampled just after the edge; holds until the next edge
    task rdy;
        #1;
        while (hreadyout !== 1'b1) @(posedge hclk) #1;
        @(posedge hclk);
    endtask
    task ahb(input logic w, input logic [31:0] a, d);
        hsel <= 1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        rdy();
        hsel <= 0;
        htrans <= 0;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask
    // First status read may predate the pending flag
    task snd(input logic c, input logic [7:0] b);
        ahb(1, 0, {23'h0, c, b});
        ahb(0, 32'h4, 0);
        do ahb(0, 32'h4, 0); while (r[0] !== 1'b0);
    endtask
    task pair(input logic [13:0] x);
        snd(0, x[7:0]);
        snd(0, {2'h0, x[13:8]});
    endtask
    // ====
    // Sequence
    initial
    begin
        #100000;
        err_total++;
        end_sim;
    end
    initial
    begin
        void'($urandom(54));
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        ahb(0, 32'h8, 0);
        chk("unmapped", 16'h0000, r[15:0]);
        rn = $urandom;
        pat = rn[15:0];
        snd(1, 8'h78);
        pair({pat[13:8], pat[7:0]});
        snd(1, 8'h79);
        snd(0, pat[15:8]);
        chk("glyph", pat, gp[15:0]);
        for (int i = 0; i < 5; i++)
        begin
            op = i[1:0];
            rn = $urandom;
            if (i == 0) rn[4:3] = 2'h0;
            snd(1, {3'h1, rn[4:3], 1'b0, op});
            chk("op", 16'(op), 16'(lop));
            chk("kind", 16'(rn[4:3]), 16'(tk));
            if (i == 3) pair(rn[13:0]);
            if (i == 3) chk("word", 16'(rn[13:0]), mw);
            snd(1, 8'h11);
            snd(0, {ty[i], rn[18:16]});
            chk("type", {8'h1, ty[i], rn[18:16]},
                {7'h0, ftv, ft, oc});
            e[0] = 0;
            e[1] = 14'h8;
            e[2] = 14'h3fff;
            e[4] = 14'h3fff;
            if (i == 0) e[3] = 0;
            for (int k = 0; k <= i; k++)
            begin
                rn = $urandom;
                e[k] = k ? rn[13:0] : 14'(16 + rn[1:0]);
                pair(e[k]);
            end
            for (int k = 0; k < 5; k++)
                chk("var", 16'(e[k]), 16'(v[k]));
            snd(1, ty[i][1] ? 8'h13 : 8'h12);
            if (i == 4) ahb(1, 0, 0);
            ahb(0, 32'h4, 0);
            chk("status", i == 4 ? 16'h0003 : 16'h0002, r[15:0]);
            for (int k = 0; k <= e[0]; k++)
            begin
                rn = $urandom;
                @(posedge hclk);
                read_modify_write_cycle <= 1;
                pix <= rn[0];
                @(posedge hclk);
                read_modify_write_cycle <= 0;
                #1;
                chk("pixel", 16'(lf(op, pat[k % 16], rn[0])),
                    16'(mp));
                chk("pixel valid", 16'h0001, 16'(mv));
                chk("pattern bit", 16'(pat[(k + 1) % 16]), 16'(pb));
                chk("busy", 16'(k < e[0]),
                    16'(fcp_link_if_i.drawing_busy));
            end
            @(posedge hclk);
        end
        rn = $urandom;
        snd(1, 8'h10);
        pair(rn[13:0]);
        snd(0, rn[23:16]);
        chk("pointer", 16'(rn[13:0]), wp);
        chk("dot", 16'h0001 << rn[19:16], bm);
        snd(1, 8'h11);
        snd(0, 8'h18);
        chk("bad type", 16'h0000, 16'(ftv));
        chk("words", 16'h0001, 16'(words));
        chk("draws", 16'h0003, 16'(nd));
        chk("fills", 16'h0002, 16'(ng));
        end_sim;
    end
endmodule
